// *** hdl/qgsc_dev.sv ***
// Gain control slave: serial frame decoder and register file.
module qgsc_dev (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	qgsc_link_if.dev link,
	input wire logic mode_serial_in,
	output logic [31:0] gain_regs_out,
	output logic [3:0] channel_on_out,
	output logic [3:0] power_high_out,
	output logic [2:0] latched_addr_out,
	output logic frame_done_out
);

	// ****************************************
	// Functions
	// ****************************************

	// One saturating attenuation step for a single channel.
	function automatic logic [4:0] qgsc_step(input logic [4:0] att,
		input logic [1:0] code);
		logic [4:0] r;
		r = att;
		if (code == qgsc_pkg::STEP_LOWER && att != qgsc_pkg::ATTEN_MIN) begin
			r = att - 5'h01;
		end else if (code == qgsc_pkg::STEP_RAISE &&
			att != qgsc_pkg::ATTEN_MAX) begin
			r = att + 5'h01;
		end
		return r;
	endfunction

	// True for the four channel register codes. The read mux and the write
	// decode share it so a read never answers for a code a write ignores.
	function automatic logic qgsc_is_chan(input logic [2:0] a);
		return (a <= qgsc_pkg::OFS_GAIN_FOURTH);
	endfunction

	// ****************************************
	// Declarations
	// ****************************************
	// Synchroniser stages and the previous sample for edge detection.
	logic [3:0] sync1_ff;
	logic [3:0] sync2_ff;
	logic [1:0] prev_ff;
	// Frame state: bit count, received bits and outgoing byte.
	logic [4:0] bit_cnt_ff;
	logic [15:0] shift_ff;
	logic [7:0] tx_ff;
	logic out_ff;
	// Register file and commit reporting.
	logic [7:0] chan_ff [0:3];
	logic [2:0] addr_ff;
	logic done_ff;
	// Decoded pin events and frame fields.
	logic sclk_rise;
	logic sclk_fall;
	logic sel_fall;
	logic sel_rise;
	logic selected;
	logic mode_on;
	logic complete;
	logic [2:0] frame_addr;
	logic [7:0] frame_data;
	logic [7:0] rd_data;

	// ****************************************
	// Pin synchronisers
	// ****************************************

	// Every link pin is asynchronous to the core clock, so all pass two flops.
	// Reset loads the idle levels (select high, clock low, mode off) so
	// that no false clock or select edge follows the release of reset.
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			sync1_ff <= 4'h2;
			sync2_ff <= 4'h2;
			prev_ff <= 2'h2;
		end else begin
			sync1_ff <= {mode_serial_in, link.serial_in_line,
				link.select_n, link.sclk};
			sync2_ff <= sync1_ff;
			prev_ff <= sync2_ff[1:0];
		end
	end

	// Edge detection looks only at the second stage and its delayed copy.
	// A select fall with mode off still clears the frame; it cannot commit.
	assign mode_on = sync2_ff[3];
	assign sclk_rise = sync2_ff[0] & ~prev_ff[0];
	assign sclk_fall = ~sync2_ff[0] & prev_ff[0];
	assign sel_fall = ~sync2_ff[1] & prev_ff[1];
	assign sel_rise = sync2_ff[1] & ~prev_ff[1];
	assign selected = mode_on & ~sync2_ff[1];
	assign complete = (bit_cnt_ff == 5'(qgsc_pkg::FRAME_BITS));
	assign frame_addr = shift_ff[qgsc_pkg::ADDR_MSB:qgsc_pkg::ADDR_LSB];
	assign frame_data = shift_ff[7:0];

	// ****************************************
	// Frame shifter
	// ****************************************

	// The counter saturates so a long frame never aliases to sixteen.
	// Edges are acted on about three core cycles late, so the master must
	// hold each clock phase for at least six core cycles.
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			bit_cnt_ff <= 5'h00;
			shift_ff <= 16'h0000;
		end else if (sel_fall) begin
			bit_cnt_ff <= 5'h00;
			shift_ff <= 16'h0000;
		end else if (selected && sclk_rise) begin
			shift_ff <= {shift_ff[14:0], sync2_ff[2]};
			if (bit_cnt_ff != 5'h1f) begin
				bit_cnt_ff <= bit_cnt_ff + 5'h01;
			end
		end
	end

	// ****************************************
	// Read data path
	// ****************************************

	// Read mux over the first byte's address; the step register reads zero.
	// The step register is write-only: its codes act once and are not kept.
	always_comb begin
		rd_data = 8'h00;
		if (qgsc_is_chan(shift_ff[2:0])) begin
			rd_data = chan_ff[shift_ff[1:0]];
		end
	end

	// The output moves only on a clock fall, once the first byte is in.
	// It is cleared at each select fall so the first byte shows zeros.
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			tx_ff <= 8'h00;
			out_ff <= 1'b0;
		end else if (sel_fall) begin
			out_ff <= 1'b0;
		end else if (selected && sclk_fall) begin
			if (bit_cnt_ff == 5'(qgsc_pkg::BYTE_BITS)) begin
				out_ff <= rd_data[7];
				tx_ff <= {rd_data[6:0], 1'b0};
			end else if (bit_cnt_ff > 5'(qgsc_pkg::BYTE_BITS) &&
				bit_cnt_ff < 5'(qgsc_pkg::FRAME_BITS)) begin
				out_ff <= tx_ff[7];
				tx_ff <= {tx_ff[6:0], 1'b0};
			end
		end
	end

	assign link.serial_out_drv = out_ff;
	assign link.serial_out_oe = selected;

	// ****************************************
	// Register file
	// ****************************************

	// Commit happens on select release only after exactly sixteen clocks.
	// Step code 11 is taken as no change, the safe reading of it.
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < 4; i++) begin
				chan_ff[i] <= qgsc_pkg::GAIN_RESET;
			end
		end else if (mode_on && sel_rise && complete &&
			!shift_ff[qgsc_pkg::DIR_POS]) begin
			if (qgsc_is_chan(frame_addr)) begin
				chan_ff[frame_addr[1:0]] <= {1'b0, frame_data[6:0]};
			end else if (frame_addr == qgsc_pkg::OFS_STEP_TRIM) begin
				for (int i = 0; i < 4; i++) begin
					chan_ff[i][4:0] <= qgsc_step(chan_ff[i][4:0],
						frame_data[2*i +: 2]);
				end
			end
		end
	end

	// Address latch; a discarded frame leaves the old address in place.
	// Read frames latch too, so the last complete access is reported.
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			addr_ff <= qgsc_pkg::ADDR_RESET;
			done_ff <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			if (mode_on && sel_rise && complete) begin
				addr_ff <= frame_addr;
				done_ff <= 1'b1;
			end
		end
	end

	// ****************************************
	// User-side outputs
	// ****************************************

	// Enables and power levels come only from the registers.
	// The power pins are not modelled: in serial mode they have no say.
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			gain_regs_out[8*i +: 8] = chan_ff[i];
			channel_on_out[i] = chan_ff[i][qgsc_pkg::ENABLE_POS];
			power_high_out[i] = chan_ff[i][qgsc_pkg::POWER_POS];
		end
	end

	assign latched_addr_out = addr_ff;
	assign frame_done_out = done_ff;

endmodule // qgsc_dev

// *** hdl/qgsc_host.sv ***
// Serial master that runs one sixteen-bit frame per request.
module qgsc_host #(
	parameter int HALF_CYC = qgsc_pkg::LINK_HALF_CYC
) (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	qgsc_link_if.host link,
	input wire logic req_in,
	input wire logic read_in,
	input wire logic [2:0] addr_in,
	input wire logic [7:0] wdata_in,
	output logic ready_out,
	output logic done_out,
	output logic [7:0] rdata_out
);

	// ****************************************
	// Declarations
	// ****************************************
	typedef enum logic [4:0] {
		QGSC_IDLE = 5'b00001,
		QGSC_SETUP = 5'b00010,
		QGSC_SHIFT = 5'b00100,
		QGSC_HOLD = 5'b01000,
		QGSC_GAP = 5'b10000
	} qgsc_hst_t;

	qgsc_hst_t st_ff;
	logic [7:0] div_ff;
	logic [15:0] tx_ff;
	logic [7:0] rx_ff;
	logic [4:0] bits_ff;
	logic sclk_ff;
	logic sel_ff;
	logic mosi_ff;
	logic done_ff;
	logic [7:0] rdata_ff;
	logic miso_s1_ff;
	logic miso_s2_ff;
	logic tick;

	// ****************************************
	// Half-period divider
	// ****************************************

	// The divider runs in every state but idle, the gap included, so every phase has full length.
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in || st_ff == QGSC_IDLE || tick) begin
			div_ff <= 8'h00;
		end else begin
			div_ff <= div_ff + 8'h01;
		end
	end

	assign tick = (div_ff == 8'(HALF_CYC - 1));

	// Returned data is from another module's pin, so it is synchronised.
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			miso_s1_ff <= 1'b1;
			miso_s2_ff <= 1'b1;
		end else begin
			miso_s1_ff <= link.serial_out_line;
			miso_s2_ff <= miso_s1_ff;
		end
	end

	// ****************************************
	// Frame sequencer
	// ****************************************

	// Clock idles low; data moves on falls and is sampled on rises.
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			st_ff <= QGSC_IDLE;
			tx_ff <= 16'h0000;
			rx_ff <= 8'h00;
			bits_ff <= 5'h00;
			sclk_ff <= 1'b0;
			sel_ff <= 1'b1;
			mosi_ff <= 1'b0;
			done_ff <= 1'b0;
			rdata_ff <= 8'h00;
		end else begin
			done_ff <= 1'b0;
			case (st_ff)
				QGSC_IDLE: begin
					if (req_in) begin
						tx_ff <= {read_in, {qgsc_pkg::RSVD_BITS{1'b0}},
							addr_in, wdata_in};
						mosi_ff <= read_in;
						sel_ff <= 1'b0;
						bits_ff <= 5'h00;
						st_ff <= QGSC_SETUP;
					end
				end
				QGSC_SETUP: begin
					if (tick) begin
						sclk_ff <= 1'b1;
						rx_ff <= {rx_ff[6:0], miso_s2_ff};
						st_ff <= QGSC_SHIFT;
					end
				end
				QGSC_SHIFT: begin
					if (tick && sclk_ff) begin
						sclk_ff <= 1'b0;
						bits_ff <= bits_ff + 5'h01;
						tx_ff <= {tx_ff[14:0], 1'b0};
						mosi_ff <= tx_ff[14];
						if (bits_ff == 5'(qgsc_pkg::FRAME_BITS - 1)) begin
							st_ff <= QGSC_HOLD;
						end
					end else if (tick) begin
						sclk_ff <= 1'b1;
						rx_ff <= {rx_ff[6:0], miso_s2_ff};
					end
				end
				QGSC_HOLD: begin
					if (tick) begin
						sel_ff <= 1'b1;
						done_ff <= 1'b1;
						rdata_ff <= rx_ff;
						st_ff <= QGSC_GAP;
					end
				end
				QGSC_GAP: begin
					if (tick) begin
						st_ff <= QGSC_IDLE;
					end
				end
				default: begin
					st_ff <= QGSC_IDLE;
				end
			endcase
		end
	end

	assign link.sclk = sclk_ff;
	assign link.select_n = sel_ff;
	assign link.serial_in_line = mosi_ff;
	assign ready_out = (st_ff == QGSC_IDLE);
	assign done_out = done_ff;
	assign rdata_out = rdata_ff;

endmodule // qgsc_host

// *** include/qgsc_link_if.sv ***
// Four-wire serial link between the master and the gain control slave.
interface qgsc_link_if;
	logic sclk;
	logic select_n;
	logic serial_in_line;
	logic serial_out_drv;
	logic serial_out_oe;
	logic serial_out_line;

	// The line is biased high externally when nobody drives it.
	assign serial_out_line = serial_out_oe ? serial_out_drv : 1'b1;

	modport dev (
		input sclk,
		input select_n,
		input serial_in_line,
		output serial_out_drv,
		output serial_out_oe
	);

	modport host (
		output sclk,
		output select_n,
		output serial_in_line,
		input serial_out_line
	);
endinterface : qgsc_link_if

// *** include/qgsc_pkg.sv ***
// Shared constants for the quad gain serial control link and its two ends.
package qgsc_pkg;

	// ****************************************
	// Frame layout
	// ****************************************
	localparam int FRAME_BITS = 16;
	localparam int BYTE_BITS = 8;
	localparam int DIR_POS = 15;
	localparam int ADDR_MSB = 10;
	localparam int ADDR_LSB = 8;
	localparam int RSVD_BITS = 4;

	// ****************************************
	// Register offsets and fields
	// ****************************************
	localparam logic [2:0] OFS_GAIN_FIRST = 3'h0;
	localparam logic [2:0] OFS_GAIN_SECOND = 3'h1;
	localparam logic [2:0] OFS_GAIN_THIRD = 3'h2;
	localparam logic [2:0] OFS_GAIN_FOURTH = 3'h3;
	localparam logic [2:0] OFS_STEP_TRIM = 3'h4;
	localparam int POWER_POS = 6;
	localparam int ENABLE_POS = 5;
	localparam logic [4:0] ATTEN_MIN = 5'h00;
	localparam logic [4:0] ATTEN_MAX = 5'h1f;
	localparam logic [7:0] GAIN_RESET = 8'h00;
	localparam logic [2:0] ADDR_RESET = 3'h0;
	localparam logic [1:0] STEP_HOLD = 2'h0;
	localparam logic [1:0] STEP_LOWER = 2'h1;
	localparam logic [1:0] STEP_RAISE = 2'h2;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CORE_CLK_NS = 8;
	localparam int LINK_HALF_NS = 64;
	localparam int LINK_HALF_CYC =
		(LINK_HALF_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;

endpackage : qgsc_pkg

// *** verification/qgsc_link_asserts.sv ***
// Link-level checker for the gain control serial link.
module qgsc_link_asserts (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic sclk,
	input wire logic select_n,
	input wire logic serial_in_line,
	input wire logic serial_out_drv,
	input wire logic serial_out_oe,
	input wire logic serial_out_line
);
	logic sclk_ff;
	logic [4:0] rise_ff;
	logic [4:0] fall_ff;

	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rst_n_in);

	// Per-frame edge counts, cleared while the slave is idle.
	always_ff @(posedge core_clk_in) begin
		sclk_ff <= sclk;
		if (!rst_n_in || select_n) begin
			rise_ff <= 5'h00;
			fall_ff <= 5'h00;
		end else begin
			rise_ff <= rise_ff + 5'(sclk && !sclk_ff);
			fall_ff <= fall_ff + 5'(!sclk && sclk_ff);
		end
	end

	// Sync flops delay the slave, so half periods need six cycles.
	sequence s_high;
		sclk [*6];
	endsequence
	sequence s_low;
		!sclk [*6];
	endsequence

	chk_out_released: assert property (
		select_n [*4] |-> !serial_out_oe)
		else $error("data out driven while idle");
	chk_line_parked: assert property (
		select_n [*4] |-> serial_out_line)
		else $error("data line not released high while idle");
	chk_frame_len: assert property (
		$rose(select_n) |-> rise_ff == 5'h10)
		else $error("frame without sixteen clocks");
	chk_idle_low: assert property (
		select_n |-> !sclk)
		else $error("clock not parked low");
	chk_high_width: assert property (
		$rose(sclk) |-> s_high)
		else $error("clock high too short");
	chk_low_width: assert property (
		$fell(sclk) |-> s_low)
		else $error("clock low too short");
	chk_drv_on_fall: assert property (
		$changed(serial_out_drv) |-> !sclk && !$past(sclk))
		else $error("data out moved near a rise");
	chk_zero_early: assert property (
		!select_n && fall_ff inside {[5'h01:5'h07]} |-> !serial_out_drv)
		else $error("data out busy in first byte");
	chk_in_stable: assert property (
		sclk |-> $stable(serial_in_line))
		else $error("data in moved while clock high");
endmodule // qgsc_link_asserts

// *** verification/quad_gain_serial_ctrl_test.sv ***
// Self-checking bench for both ends of the gain control link.
module quad_gain_serial_ctrl_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HALF = 6;
	logic core_clk_in;
	logic rst_n_in = 1'b0;
	logic mode = 1'b1;
	logic mode_b = 1'b0;
	logic req = 1'b0;
	logic rd = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic ready, done, done_a, done_b, sclk_q;
	logic [2:0] lat, lat_b;
	logic [7:0] rdata;
	logic [31:0] regs, regs_b;
	logic [3:0] on, pw;
	logic [15:0] mon_in, mon_out;
	logic [7:0] model [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
	int bad_count = 0;
	int num_checks = 0;
	int cyc = 0;
	int done_cnt = 0;
	int done_a_cnt = 0;
	qgsc_link_if link();
	qgsc_link_if link_b();

	qgsc_host #(.HALF_CYC(HALF)) i_qgsc_host (.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in), .link(link), .req_in(req), .read_in(rd),
		.addr_in(addr), .wdata_in(wdata), .ready_out(ready),
		.done_out(done), .rdata_out(rdata));
	qgsc_dev i_qgsc_dev (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
		.link(link), .mode_serial_in(mode), .gain_regs_out(regs),
		.channel_on_out(on), .power_high_out(pw),
		.latched_addr_out(lat), .frame_done_out(done_a));
	// Second slave, driven by hand to break the frame rules.
	qgsc_dev i_qgsc_dev_2 (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
		.link(link_b), .mode_serial_in(mode_b), .gain_regs_out(regs_b),
		.channel_on_out(), .power_high_out(), .latched_addr_out(lat_b),
		.frame_done_out(done_b));
	qgsc_link_asserts i_qgsc_link_asserts (.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in), .sclk(link.sclk), .select_n(link.select_n),
		.serial_in_line(link.serial_in_line),
		.serial_out_drv(link.serial_out_drv),
		.serial_out_oe(link.serial_out_oe),
		.serial_out_line(link.serial_out_line));

	initial begin
		core_clk_in = 1'b0;
		forever #4 core_clk_in = ~core_clk_in;
	end

	// Record both data lines at each clock rise; also cut off a hang.
	always @(posedge core_clk_in) begin
		sclk_q <= link.sclk;
		if (link.sclk && !sclk_q) begin
			mon_in <= {mon_in[14:0], link.serial_in_line};
			mon_out <= {mon_out[14:0], link.serial_out_line};
		end
		if (done_b)
			done_cnt++;
		if (done_a)
			done_a_cnt++;
		cyc++;
		if (cyc > 20000) begin
			bad_count++;
			finish_test();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: seen %h want %h", $time, seen, exp);
		end
	endtask

	// One host frame, then the slave state against the bench model.
	task automatic acc(input logic r, input logic [2:0] a,
		input logic [7:0] d);
		logic [7:0] want;
		logic [1:0] c;
		logic [3:0] e_on, e_pw;
		int base;
		base = done_a_cnt;
		rd <= r;
		addr <= a;
		wdata <= d;
		req <= 1'b1;
		do @(posedge core_clk_in); while (ready !== 1'b1);
		req <= 1'b0;
		do @(posedge core_clk_in); while (done !== 1'b1);
		want = (a < 3'h4) ? model[a] : 8'h00;
		if (!r && a < 3'h4)
			model[a] = d & 8'h7f;
		for (int i = 0; i < 4; i++) begin
			c = (!r && a == qgsc_pkg::OFS_STEP_TRIM) ? d[2*i+:2] : 2'h0;
			if (c == qgsc_pkg::STEP_LOWER && model[i][4:0] != 5'h00)
				model[i][4:0] -= 5'h01;
			if (c == qgsc_pkg::STEP_RAISE && model[i][4:0] != 5'h1f)
				model[i][4:0] += 5'h01;
			e_on[i] = model[i][qgsc_pkg::ENABLE_POS];
			e_pw[i] = model[i][qgsc_pkg::POWER_POS];
		end
		repeat (6) @(posedge core_clk_in);
		check(mon_in, {r, 4'h0, a, d});
		if (r)
			check(mon_out[7:0], want);
		if (r)
			check(rdata, want);
		check(regs, {model[3], model[2], model[1], model[0]});
		check({on, pw}, {e_on, e_pw});
		check(lat, a);
		check(done_a_cnt, base + 1);
	endtask

	// Hand-made frame of n clocks on the second link.
	task automatic raw(input int n, input logic [15:0] w);
		link_b.select_n <= 1'b0;
		for (int i = 0; i < n; i++) begin
			link_b.serial_in_line <= w[15-i%16];
			repeat (HALF) @(posedge core_clk_in);
			link_b.sclk <= 1'b1;
			repeat (HALF) @(posedge core_clk_in);
			link_b.sclk <= 1'b0;
		end
		repeat (HALF) @(posedge core_clk_in);
		check(link_b.serial_out_oe, mode_b);
		link_b.select_n <= 1'b1;
		link_b.serial_in_line <= ~w[0];
		repeat (8) @(posedge core_clk_in);
	endtask

	task automatic test_reset();
		check(regs, 32'h0);
		check(lat, 3'h0);
		check(link.serial_out_line, 1'b1);
	endtask

	// Bit 7 written as one must read back as zero.
	task automatic test_regs();
		logic [7:0] v [4] = '{8'h80, 8'h7f, 8'h30, 8'h45};
		for (int i = 0; i < 4; i++)
			acc(1'b0, 3'(i), v[i]);
		for (int i = 0; i < 4; i++)
			acc(1'b1, 3'(i), 8'hff);
		acc(1'b0, 3'h5, 8'h55);
		acc(1'b1, 3'h7, 8'h00);
	endtask

	// Both step limits, every code, then a read of the step place.
	task automatic test_steps();
		acc(1'b0, 3'h4, 8'he9);
		acc(1'b0, 3'h4, 8'h14);
		acc(1'b1, 3'h4, 8'h00);
	endtask

	task automatic test_raw();
		raw(16, 16'h002a);
		check(regs_b, 32'h0);
		mode_b <= 1'b1;
		repeat (4) @(posedge core_clk_in);
		raw(15, 16'h002a);
		check(regs_b, 32'h0);
		raw(16, 16'h0135);
		check(regs_b, 32'h3500);
		raw(16, 16'h8300);
		check({lat_b, regs_b}, {3'h3, 32'h3500});
		check(done_cnt, 2);
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		link_b.sclk = 1'b0;
		link_b.select_n = 1'b1;
		link_b.serial_in_line = 1'b0;
		repeat (4) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		repeat (2) @(posedge core_clk_in);
		test_reset();
		test_regs();
		test_steps();
		test_raw();
		finish_test();
	end
endmodule // quad_gain_serial_ctrl_test
